// ---- logic/op_sequencer.sv ----
// machine-cycle sequencer for immediate and control instructions
`timescale 1ns/10ps
// How it works
// - compare: fetch, alu, register read, alu, read at pc+2, two alu.
// - load immediate: fetch, two alu, read pc+2, alu address, write.
// - load base 5 / load mask 7 cycles: fetch, two alu, read pc+2.
// - save base/flags: fetch, alu, alu address, write internal value.
// - external 5 / halt 6: bit-io strobe in cycle 4 with code.
// - return: alu forms base+30, reads flags slot then counter slot.
// - return cycle 6 reads base slot, one final alu, then restores base.
module op_sequencer (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        start,
  input  wire op_seq_pkg::op_type          op,
  input  wire logic [3:0]                  reg_num,
  input  wire logic [15:0]                 ext_code,
  input  wire logic [15:0]                 pc_in,
  input  wire logic [15:0]                 base_in,
  input  wire logic [15:0]                 flags_in,
  input  wire logic [15:0]                 read_data,
  output logic                             busy,
  output logic                             done,
  output logic [3:0]                       cycle_num,
  output op_seq_pkg::cyc_type              cycle_kind,
  output logic [15:0]                      operand,
  output logic [15:0]                      base_out,
  output logic [15:0]                      pc_out,
  output logic [15:0]                      flags_out,
  output logic [15:0]                      addr_bus,
  output logic [15:0]                      data_out,
  output logic                             data_oe,
  output logic                             mem_enable,
  output logic                             mem_write,
  output logic                             bit_io_strobe
);
  import op_seq_pkg::*;

  op_seq_bus_if bus ();

  // ----------------------------------------------------------------
  // sequence state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } state_type;

  state_type   state_r, state_nxt;
  op_type      op_r, op_nxt;
  logic [3:0]  cyc_r, cyc_nxt, len;
  logic [3:0]  reg_r, reg_nxt;
  logic [15:0] code_r, code_nxt, pc_r, pc_nxt;
  logic [15:0] wbase_r, wbase_nxt, flags_r, flags_nxt;
  logic [15:0] opnd_r, opnd_nxt, ptr_r, ptr_nxt;
  logic [15:0] npc_r, npc_nxt, nbase_r, nbase_nxt, nflg_r, nflg_nxt;
  logic        done_r, done_nxt;
  cyc_type     kind;
  logic [15:0] addr, wdata;
  logic        drive;
  logic [15:0] reg_addr;

  assign reg_addr = wbase_r + {11'h000, reg_r, 1'b0};

  always_comb begin
    unique case (op_r)
      OP_COMPARE_IMM:   len = CI_LEN;
      OP_LOAD_REG_IMM:  len = LI_LEN;
      OP_LOAD_BASE_IMM: len = LOAD_WORKSPACE_POINTER_IMMEDIATE_LEN;
      OP_LOAD_MASK:     len = LOAD_INTERRUPT_MASK_LEN;
      OP_SAVE_BASE,
      OP_SAVE_FLAGS:    len = STORE_LEN;
      OP_EXT_CONTROL:   len = EXT_LEN;
      OP_HALT:          len = HALT_LEN;
      default:          len = RET_LEN;
    endcase
  end

  // ----------------------------------------------------------------
  // cycle decode
  // ----------------------------------------------------------------
  always_comb begin
    kind  = CYC_ALU;
    addr  = RESET_VALUE;
    wdata = RESET_VALUE;
    drive = 1'b0;
    if (cyc_r == 4'h1) begin
      kind = CYC_READ;
      addr = pc_r;
    end else begin
      unique case (op_r)
        OP_COMPARE_IMM: begin
          if (cyc_r == 4'h3) begin
            kind = CYC_READ;
            addr = reg_addr;
          end else if (cyc_r == 4'h5) begin
            kind = CYC_READ;
            addr = pc_r + PC_STEP;
          end
        end
        OP_LOAD_REG_IMM, OP_LOAD_BASE_IMM, OP_LOAD_MASK: begin
          if (cyc_r == 4'h4) begin
            kind = CYC_READ;
            addr = pc_r + PC_STEP;
          end else if (op_r == OP_LOAD_REG_IMM && cyc_r == 4'h5) begin
            addr = reg_addr;
          end else if (op_r == OP_LOAD_REG_IMM && cyc_r == 4'h6) begin
            kind  = CYC_WRITE;
            addr  = reg_addr;
            wdata = opnd_r;
            drive = 1'b1;
          end
        end
        OP_SAVE_BASE, OP_SAVE_FLAGS: begin
          if (cyc_r == 4'h3) begin
            addr = reg_addr;
          end else if (cyc_r == 4'h4) begin
            kind  = CYC_WRITE;
            addr  = reg_addr;
            wdata = (op_r == OP_SAVE_BASE) ? wbase_r : flags_r;
            drive = 1'b1;
          end
        end
        OP_EXT_CONTROL, OP_HALT: begin
          if (cyc_r == IO_CYCLE) begin
            kind  = CYC_BITIO;
            addr  = (op_r == OP_HALT) ? IDLE_CODE : code_r;
            drive = 1'b1;
          end else if (!(op_r == OP_HALT && cyc_r == HALT_LEN)) begin
            drive = 1'b1;
          end
        end
        default: begin
          if (cyc_r == 4'h3) begin
            addr = wbase_r + CTX_OFFSET;
          end else if (cyc_r == 4'h4) begin
            kind = CYC_READ;
            addr = ptr_r;
          end else if (cyc_r == 4'h5) begin
            kind = CYC_READ;
            addr = wbase_r + SLOT_PC;
          end else if (cyc_r == 4'h6) begin
            kind = CYC_READ;
            addr = wbase_r + SLOT_BASE;
          end
        end
      endcase
    end
  end

  assign bus.valid      = (state_r == ST_RUN);
  assign bus.kind       = kind;
  assign bus.addr       = addr;
  assign bus.wdata      = wdata;
  assign bus.drive_data = drive;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    cyc_nxt   = cyc_r;
    reg_nxt   = reg_r;
    code_nxt  = code_r;
    pc_nxt    = pc_r;
    wbase_nxt = wbase_r;
    flags_nxt = flags_r;
    opnd_nxt  = opnd_r;
    ptr_nxt   = ptr_r;
    npc_nxt   = npc_r;
    nbase_nxt = nbase_r;
    nflg_nxt  = nflg_r;
    done_nxt  = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = ST_RUN;
          op_nxt    = op;
          cyc_nxt   = 4'h1;
          reg_nxt   = reg_num;
          code_nxt  = ext_code;
          pc_nxt    = pc_in;
          wbase_nxt = base_in;
          flags_nxt = flags_in;
        end
      end
      ST_RUN: begin
        if (kind == CYC_READ && cyc_r != 4'h1) begin
          if (op_r == OP_RETURN) begin
            if (cyc_r == 4'h4) nflg_nxt = read_data;
            if (cyc_r == 4'h5) npc_nxt = read_data;
            if (cyc_r == 4'h6) nbase_nxt = read_data;
          end else if (addr == pc_r + PC_STEP) begin
            opnd_nxt = read_data;
          end
        end
        if (op_r == OP_RETURN && cyc_r == 4'h3) begin
          ptr_nxt = wbase_r + SLOT_FLAGS;
        end
        if (cyc_r == len) begin
          state_nxt = ST_IDLE;
          cyc_nxt   = 4'h0;
          done_nxt  = 1'b1;
          if (op_r == OP_RETURN) wbase_nxt = nbase_r;
          if (op_r == OP_LOAD_BASE_IMM) wbase_nxt = opnd_r;
        end else begin
          cyc_nxt = cyc_r + 4'h1;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      op_r    <= OP_COMPARE_IMM;
      cyc_r   <= 4'h0;
      reg_r   <= 4'h0;
      code_r  <= RESET_VALUE;
      pc_r    <= RESET_VALUE;
      wbase_r <= RESET_VALUE;
      flags_r <= RESET_VALUE;
      opnd_r  <= RESET_VALUE;
      ptr_r   <= RESET_VALUE;
      npc_r   <= RESET_VALUE;
      nbase_r <= RESET_VALUE;
      nflg_r  <= RESET_VALUE;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      cyc_r   <= cyc_nxt;
      reg_r   <= reg_nxt;
      code_r  <= code_nxt;
      pc_r    <= pc_nxt;
      wbase_r <= wbase_nxt;
      flags_r <= flags_nxt;
      opnd_r  <= opnd_nxt;
      ptr_r   <= ptr_nxt;
      npc_r   <= npc_nxt;
      nbase_r <= nbase_nxt;
      nflg_r  <= nflg_nxt;
      done_r  <= done_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign busy       = (state_r == ST_RUN);
  assign done       = done_r;
  assign cycle_num  = cyc_r;
  assign cycle_kind = kind;
  assign operand    = opnd_r;
  assign base_out   = wbase_r;
  assign pc_out     = npc_r;
  assign flags_out  = nflg_r;

  op_seq_cycle_drv u_drv (
    .clk           (clk),
    .rst           (rst),
    .bus           (bus.drv),
    .addr_bus      (addr_bus),
    .data_out      (data_out),
    .data_oe       (data_oe),
    .mem_enable    (mem_enable),
    .mem_write     (mem_write),
    .bit_io_strobe (bit_io_strobe)
  );
endmodule : op_sequencer

// ---- logic/op_seq_pkg.sv ----
// constants and types for the immediate and control op sequencer
package op_seq_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam logic [15:0] PC_STEP     = 16'h0002;
  localparam logic [15:0] CTX_OFFSET  = 16'h001E;
  localparam logic [15:0] SLOT_FLAGS  = 16'h001E;
  localparam logic [15:0] SLOT_PC     = 16'h001C;
  localparam logic [15:0] SLOT_BASE   = 16'h001A;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  localparam logic [15:0] IDLE_CODE   = 16'h0002;
  localparam logic [3:0]  IO_CYCLE    = 4'h4;
  localparam logic [3:0]  CI_LEN      = 4'h7;
  localparam logic [3:0]  LI_LEN      = 4'h6;
  localparam logic [3:0]  LOAD_WORKSPACE_POINTER_IMMEDIATE_LEN    = 4'h5;
  localparam logic [3:0]  LOAD_INTERRUPT_MASK_LEN    = 4'h7;
  localparam logic [3:0]  STORE_LEN   = 4'h4;
  localparam logic [3:0]  EXT_LEN     = 4'h5;
  localparam logic [3:0]  HALT_LEN    = 4'h6;
  localparam logic [3:0]  RET_LEN     = 4'h7;

  typedef enum logic [3:0] {
    OP_COMPARE_IMM   = 4'h0,
    OP_LOAD_REG_IMM  = 4'h1,
    OP_LOAD_BASE_IMM = 4'h2,
    OP_LOAD_MASK     = 4'h3,
    OP_SAVE_BASE     = 4'h4,
    OP_SAVE_FLAGS    = 4'h5,
    OP_EXT_CONTROL   = 4'h6,
    OP_HALT          = 4'h7,
    OP_RETURN        = 4'h8
  } op_type;

  typedef enum logic [3:0] {
    CYC_ALU   = 4'h1,
    CYC_READ  = 4'h2,
    CYC_WRITE = 4'h4,
    CYC_BITIO = 4'h8
  } cyc_type;
endpackage : op_seq_pkg

// ---- logic/op_seq_bus_if.sv ----
// interface between sequencer core and cycle driver
`timescale 1ns/10ps
interface op_seq_bus_if;
  import op_seq_pkg::*;
  cyc_type           kind;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              drive_data;
  logic              valid;
  modport core (output kind, addr, wdata, drive_data, valid);
  modport drv  (input  kind, addr, wdata, drive_data, valid);
endinterface : op_seq_bus_if

// ---- logic/op_seq_cycle_drv.sv ----
// registers one machine cycle onto the memory and bit-io pins
`timescale 1ns/10ps
module op_seq_cycle_drv (
  input  wire logic                        clk,
  input  wire logic                        rst,
  op_seq_bus_if.drv                        bus,
  output logic [op_seq_pkg::ADDR_W-1:0]    addr_bus,
  output logic [op_seq_pkg::DATA_W-1:0]    data_out,
  output logic                             data_oe,
  output logic                             mem_enable,
  output logic                             mem_write,
  output logic                             bit_io_strobe
);
  import op_seq_pkg::*;

  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] data_r, data_nxt;
  logic              oe_r, oe_nxt, men_r, men_nxt;
  logic              we_r, we_nxt, io_r, io_nxt;

  always_comb begin
    addr_nxt = addr_r;
    data_nxt = data_r;
    oe_nxt   = 1'b0;
    men_nxt  = 1'b0;
    we_nxt   = 1'b0;
    io_nxt   = 1'b0;
    if (bus.valid) begin
      addr_nxt = bus.addr;
      data_nxt = bus.wdata;
      oe_nxt   = bus.drive_data;
      men_nxt  = (bus.kind == CYC_READ) || (bus.kind == CYC_WRITE);
      we_nxt   = (bus.kind == CYC_WRITE);
      io_nxt   = (bus.kind == CYC_BITIO);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_r <= RESET_VALUE;
      data_r <= RESET_VALUE;
      oe_r   <= 1'b0;
      men_r  <= 1'b0;
      we_r   <= 1'b0;
      io_r   <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      oe_r   <= oe_nxt;
      men_r  <= men_nxt;
      we_r   <= we_nxt;
      io_r   <= io_nxt;
    end
  end

  assign addr_bus      = addr_r;
  assign data_out      = data_r;
  assign data_oe       = oe_r;
  assign mem_enable    = men_r;
  assign mem_write     = we_r;
  assign bit_io_strobe = io_r;
endmodule : op_seq_cycle_drv

// ---- testbench/op_sequencer_asserts.sv ----
// port checker for the op sequencer
`timescale 1ns/10ps
module op_sequencer_asserts (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                start,
  input wire op_seq_pkg::op_type  op,
  input wire logic                busy,
  input wire logic                done,
  input wire logic [3:0]          cycle_num,
  input wire op_seq_pkg::cyc_type cycle_kind,
  input wire logic                data_oe,
  input wire logic                mem_enable,
  input wire logic                mem_write,
  input wire logic                bit_io_strobe
);
  import op_seq_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // cycle orders
  // ----------------------------------------
  sequence cmp_steps;
    cycle_kind == CYC_READ ##1 cycle_kind == CYC_ALU ##1
    cycle_kind == CYC_READ ##1 cycle_kind == CYC_ALU ##1
    cycle_kind == CYC_READ ##1 cycle_kind == CYC_ALU [*2] ##1 done;
  endsequence
  sequence ldr_steps;
    cycle_kind == CYC_READ ##1 cycle_kind == CYC_ALU [*2] ##1
    cycle_kind == CYC_READ ##1 cycle_kind == CYC_ALU ##1
    cycle_kind == CYC_WRITE ##1 done;
  endsequence
  sequence save_steps;
    cycle_kind == CYC_READ ##1 cycle_kind == CYC_ALU [*2] ##1
    cycle_kind == CYC_WRITE ##1 done;
  endsequence
  sequence halt_steps;
    cycle_kind == CYC_READ ##1 cycle_kind == CYC_ALU [*2] ##1
    cycle_kind == CYC_BITIO ##1 cycle_kind == CYC_ALU [*2] ##1
    (done && !data_oe);
  endsequence
  sequence ret_steps;
    cycle_kind == CYC_READ ##1 cycle_kind == CYC_ALU [*2] ##1
    cycle_kind == CYC_READ [*3] ##1 cycle_kind == CYC_ALU ##1 done;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  alu_quiet_a: assert property (busy && cycle_kind == CYC_ALU |=>
    !mem_enable && !mem_write) else $error("alu cycle moved memory");
  write_pins_a: assert property (busy && cycle_kind == CYC_WRITE |=>
    mem_enable && mem_write && data_oe) else $error("write pins wrong");
  bitio_slot_a: assert property (busy && cycle_kind == CYC_BITIO |->
    cycle_num == 4'h4 ##1 bit_io_strobe && !mem_enable)
    else $error("bit-io cycle wrong");
  compare_order_a: assert property (start && !busy &&
    op == OP_COMPARE_IMM |=> cmp_steps) else $error("compare order");
  load_order_a: assert property (start && !busy &&
    op == OP_LOAD_REG_IMM |=> ldr_steps) else $error("load order");
  save_order_a: assert property (start && !busy &&
    (op == OP_SAVE_BASE || op == OP_SAVE_FLAGS) |=> save_steps)
    else $error("save order");
  halt_order_a: assert property (start && !busy &&
    op == OP_HALT |=> halt_steps) else $error("halt order");
  return_order_a: assert property (start && !busy &&
    op == OP_RETURN |=> ret_steps) else $error("return order");
endmodule : op_sequencer_asserts

bind op_sequencer op_sequencer_asserts i_op_sequencer_asserts (
  .clk(clk), .rst(rst), .start(start), .op(op), .busy(busy),
  .done(done), .cycle_num(cycle_num), .cycle_kind(cycle_kind),
  .data_oe(data_oe), .mem_enable(mem_enable), .mem_write(mem_write),
  .bit_io_strobe(bit_io_strobe)
);

// ---- testbench/op_seq_memory.sv ----
// external memory model answering the sequencer's reads
`timescale 1ns/10ps
module op_seq_memory (
  input  wire op_seq_pkg::cyc_type cycle_kind,
  input  wire logic [3:0]          cycle_num,
  output logic [15:0]              read_data
);
  import op_seq_pkg::*;
  // word tagged with the cycle; bus shows its inverse when not read
  always_comb begin
    read_data = {8'h5A, 4'h0, cycle_num};
    if (cycle_kind != CYC_READ) read_data = ~read_data;
  end
endmodule : op_seq_memory

// ---- testbench/op_sequencer_test.sv ----
// self-checking bench for the op sequencer
`timescale 1ns/10ps
module op_sequencer_test;
  import op_seq_pkg::*;
  localparam logic [15:0] P = 16'h1000, B = 16'h0400, F = 16'h0C30;
  localparam logic [15:0] RA = 16'h0406, X = 16'hFFFF;
  logic clk, rst, start, busy, done, data_oe, mem_enable, mem_write;
  logic bit_io_strobe;
  op_type op;
  cyc_type cycle_kind;
  logic [3:0] reg_num, cycle_num;
  logic [15:0] ext_code, pc_in, base_in, flags_in, read_data, operand;
  logic [15:0] base_out, pc_out, flags_out, addr_bus, data_out;
  logic [15:0] exp_addr [1:7];
  int err_total, tests_run, cycles;
  op_sequencer i_op_sequencer (.clk(clk), .rst(rst), .start(start), .op(op),
    .reg_num(reg_num), .ext_code(ext_code), .pc_in(pc_in), .base_in(base_in),
    .flags_in(flags_in), .read_data(read_data), .busy(busy), .done(done),
    .cycle_num(cycle_num), .cycle_kind(cycle_kind), .operand(operand),
    .base_out(base_out), .pc_out(pc_out), .flags_out(flags_out),
    .addr_bus(addr_bus), .data_out(data_out), .data_oe(data_oe),
    .mem_enable(mem_enable), .mem_write(mem_write),
    .bit_io_strobe(bit_io_strobe));
  op_seq_memory i_op_seq_memory (.cycle_kind(cycle_kind),
    .cycle_num(cycle_num), .read_data(read_data));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic check_word(input string what, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask : check_word
  // ----------------------------------------
  // one instruction, pins checked cycle by cycle
  // ----------------------------------------
  task automatic run_op(input op_type o, input string seq,
                        input logic [15:0] wd);
    int k;
    logic [2:0] e;
    op = o;
    start = 1'b1;
    @(posedge clk); #1;
    op = OP_HALT;
    for (k = 1; k <= seq.len(); k++) begin
      @(posedge clk); #1;
      start = 1'b0;
      e = seq[k-1] == "R" ? 3'b100 : seq[k-1] == "W" ? 3'b110 :
          seq[k-1] == "B" ? 3'b001 : 3'b000;
      check_word("pins", {13'h0, e},
                 {13'h0, mem_enable, mem_write, bit_io_strobe});
      if (exp_addr[k] !== X)
        check_word("addr", exp_addr[k], addr_bus);
      if (e == 3'b110) check_word("wdata", wd, data_out);
      check_word("done", {15'h0, k == seq.len()}, {15'h0, done});
      check_word("busy", {15'h0, k != seq.len()}, {15'h0, busy});
      check_word("cycle", (k < seq.len()) ? 16'(k + 1) : 16'h0,
                 {12'h0, cycle_num});
      if (o == OP_HALT && k == 6)
        check_word("float", 16'h0, {15'h0, data_oe});
    end
    @(posedge clk); #1;
    $display("test %s finished", seq);
  endtask : run_op
  task automatic test_compare;
    exp_addr = '{P, X, RA, X, 16'h1002, X, X};
    run_op(OP_COMPARE_IMM, "RARARAA", X);
    check_word("operand", 16'h5A05, operand);
  endtask : test_compare
  task automatic test_load_reg;
    exp_addr = '{P, X, X, 16'h1002, RA, RA, X};
    run_op(OP_LOAD_REG_IMM, "RAARAW", 16'h5A04);
  endtask : test_load_reg
  task automatic test_load_base_mask;
    exp_addr = '{P, X, X, 16'h1002, X, X, X};
    run_op(OP_LOAD_BASE_IMM, "RAARA", X);
    check_word("base", 16'h5A04, base_out);
    run_op(OP_LOAD_MASK, "RAARAAA", X);
    check_word("operand", 16'h5A04, operand);
  endtask : test_load_base_mask
  task automatic test_save;
    exp_addr = '{P, X, RA, RA, X, X, X};
    run_op(OP_SAVE_BASE, "RAAW", B);
    run_op(OP_SAVE_FLAGS, "RAAW", F);
  endtask : test_save
  task automatic test_ext_halt;
    exp_addr = '{P, X, X, 16'h00C0, X, X, X};
    run_op(OP_EXT_CONTROL, "RAABA", X);
    exp_addr[4] = IDLE_CODE;
    run_op(OP_HALT, "RAABAA", X);
  endtask : test_ext_halt
  task automatic test_return;
    exp_addr = '{P, X, 16'h041E, 16'h041E, 16'h041C, 16'h041A, X};
    run_op(OP_RETURN, "RAARRRA", X);
    check_word("flags", 16'h5A04, flags_out);
    check_word("pc", 16'h5A05, pc_out);
    check_word("base", 16'h5A06, base_out);
  endtask : test_return
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    err_total = 0;
    tests_run = 0;
    cycles = 0;
    rst = 1'b1;
    start = 1'b0;
    op = OP_COMPARE_IMM;
    reg_num = 4'h3;
    ext_code = 16'h00C0;
    pc_in = P;
    base_in = B;
    flags_in = F;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    test_compare();
    test_load_reg();
    test_load_base_mask();
    test_save();
    test_ext_halt();
    test_return();
    tally_and_finish();
  end
endmodule : op_sequencer_test
